// ===== design/timing_router_pkg.sv
// constants shared by the timing signal router and its source selectors
package timing_router_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_DIO = 8;
  localparam int NUM_PFI = 10;
  localparam int NUM_SIG = 13;
  localparam int SEL_W = 4;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMEBASE_HZ = 20_000_000;
  // pclk cycles per timebase period; also the width of every strobe pulse
  localparam int TB_DIV_CYCLES = CLK_HZ / TIMEBASE_HZ;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_DIO_DIR = 8'h00;
  localparam logic [7:0] ADDR_DIO_OUT = 8'h04;
  localparam logic [7:0] ADDR_DIO_IN = 8'h08;
  localparam logic [7:0] ADDR_PFI_OE = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_SEL_LO = 8'h14;
  localparam logic [7:0] ADDR_SEL_HI = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;

  // control register fields and reset value
  localparam int CTRL_ANALOG_TRIG_BIT = 0;
  localparam int CTRL_PRETRIG_BIT = 1;
  localparam int CTRL_SCAN_PULSE_EN_BIT = 2;
  localparam int CTRL_STROBE_N_BIT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h8;
  localparam logic [7:0] DIO_RESET = 8'h00;
  localparam logic [9:0] PFI_OE_RESET = 10'h000;

  // status register fields
  localparam int STAT_ACQUISITION_START_TRIGGER_BIT = 16;
  localparam int STAT_POSTTRIGGER_START_TRIGGER_BIT = 17;

  // ------------------------------------------------------------
  // source select codes: 0..9 pick a function pin
  // ------------------------------------------------------------
  localparam logic [3:0] SEL_INTERNAL = 4'ha;
  localparam logic [3:0] SEL_CTR0 = 4'hb;
  localparam int SEL_PER_WORD = 8;

  // timing signal indices
  localparam int SIG_CONVERT = 0;
  localparam int SIG_UPDATE = 1;
  localparam int SIG_SCAN_START = 2;
  localparam int SIG_ACQ_TRIG = 3;
  localparam int SIG_POST_TRIG = 4;
  localparam int SIG_CTR0_SRC = 5;
  localparam int SIG_CTR0_GATE = 6;
  localparam int SIG_CTR1_SRC = 7;
  localparam int SIG_CTR1_GATE = 8;
  localparam int SIG_WAVE_TRIG = 9;

  // digital lines that steer the counters' count direction
  localparam int DIO_UPDOWN_CTR0 = 6;
  localparam int DIO_UPDOWN_CTR1 = 7;

  // acquisition sequence states
  typedef enum logic [3:0] {
    ACQ_IDLE = 4'b0001,
    ACQ_POSTONLY = 4'b0010,
    ACQ_PRETRIG = 4'b0100,
    ACQ_POSTTRIG = 4'b1000
  } acq_state_type;

endpackage : timing_router_pkg

// ===== design/timing_source_select.sv
// one timing signal source selector: any function pin, internal or counter 0
module timing_source_select
  import timing_router_pkg::*;
#(
  parameter int PINS = NUM_PFI
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [SEL_W-1:0] sel,
  input wire logic [PINS-1:0] pin_in,
  input wire logic internal_src,
  input wire logic counter_zero_output,
  output logic routed_ff
);

  logic nxt_routed;

  initial begin
    if (PINS > int'(SEL_INTERNAL)) begin
      $error("too many pins for select code");
    end
  end

  // pin codes first; unused codes give a quiet low
  always_comb begin
    nxt_routed = 1'b0;
    if (int'(sel) < PINS) begin
      nxt_routed = pin_in[sel];
    end else if (sel == SEL_INTERNAL) begin
      nxt_routed = internal_src;
    end else if (sel == SEL_CTR0) begin
      nxt_routed = counter_zero_output;
    end
  end

  // registered so every routed signal leaves from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routed_ff <= 1'b0;
    end else begin
      routed_ff <= nxt_routed;
    end
  end

endmodule : timing_source_select

// ===== design/timing_signal_router_dio.sv
// timing signal router, function pin drivers and general-purpose digital lines
module timing_signal_router_dio
  import timing_router_pkg::*;
#(
  parameter int DIO_LINES = NUM_DIO,
  parameter int PFI_PINS = NUM_PFI,
  parameter int TIMING_SIGNALS = NUM_SIG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [DIO_LINES-1:0] gp_digital_lines_in,
  output logic [DIO_LINES-1:0] gp_digital_lines_out,
  output logic [DIO_LINES-1:0] gp_digital_lines_oe,
  input wire logic [PFI_PINS-1:0] programmable_function_pin_in,
  output logic [PFI_PINS-1:0] programmable_function_pin_out,
  output logic [PFI_PINS-1:0] programmable_function_pin_oe,
  input wire logic sample_interval_terminal_count,
  input wire logic [TIMING_SIGNALS-1:1] internal_timing_src,
  input wire logic counter_zero_output,
  input wire logic acquisition_done,
  output logic [TIMING_SIGNALS-1:0] routed_timing,
  output logic counter_zero_up_down,
  output logic counter_one_up_down,
  output logic analog_trigger_in,
  output logic timebase_tick,
  output logic per_conversion_scan_pulse,
  output logic software_strobe_n,
  output logic acquisition_start_trigger,
  output logic posttrigger_start_trigger
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  initial begin
    if (DIO_LINES != NUM_DIO) begin
      $error("need eight digital lines");
    end
    if (PFI_PINS != NUM_PFI) begin
      $error("need ten function pins");
    end
    if (TIMING_SIGNALS != NUM_SIG) begin
      $error("need thirteen timing signals");
    end
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [DIO_LINES-1:0] dio_dir_ff;
  logic [DIO_LINES-1:0] dio_out_ff;
  logic [PFI_PINS-1:0] pfi_oe_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [SEL_W*NUM_SIG-1:0] sel_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic [PFI_PINS-1:0] pfi_out_ff;
  logic [PFI_PINS-1:0] nxt_pfi_out;
  logic [PFI_PINS-1:0] pfi_to_selectors;
  logic [TIMING_SIGNALS-1:0] internal_src;
  logic [TIMING_SIGNALS-1:0] routed;
  logic [TIMING_SIGNALS-1:0] routed_prev_ff;
  logic [TIMING_SIGNALS-1:0] routed_rise;
  logic [$clog2(TB_DIV_CYCLES)-1:0] tb_cnt_ff;
  logic tick_ff;
  logic wr_en;
  logic setup;
  logic mapped;
  logic counter_zero_up_down_ff;
  logic counter_one_up_down_ff;
  logic analog_trigger_in_ff;
  logic [3:0] evt;
  logic [3:0] pulse_ff;
  acq_state_type acq_state_ff;
  acq_state_type nxt_acq_state;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // zero wait states; read data is captured in the setup cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;

  always_comb begin
    unique case (paddr)
      ADDR_DIO_DIR, ADDR_DIO_OUT, ADDR_DIO_IN, ADDR_PFI_OE: mapped = 1'b1;
      ADDR_CTRL, ADDR_SEL_LO, ADDR_SEL_HI, ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read multiplexer; reserved bits read as zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_DIO_DIR: nxt_prdata[DIO_LINES-1:0] = dio_dir_ff;
      ADDR_DIO_OUT: nxt_prdata[DIO_LINES-1:0] = dio_out_ff;
      ADDR_DIO_IN: nxt_prdata[DIO_LINES-1:0] = gp_digital_lines_in;
      ADDR_PFI_OE: nxt_prdata[PFI_PINS-1:0] = pfi_oe_ff;
      ADDR_CTRL: nxt_prdata[CTRL_W-1:0] = ctrl_ff;
      ADDR_SEL_LO: nxt_prdata = sel_ff[SEL_W*SEL_PER_WORD-1:0];
      ADDR_SEL_HI: nxt_prdata[SEL_W*(NUM_SIG-SEL_PER_WORD)-1:0] = sel_ff[SEL_W*NUM_SIG-1:SEL_W*SEL_PER_WORD];
      ADDR_STATUS: begin
        nxt_prdata[TIMING_SIGNALS-1:0] = routed;
        nxt_prdata[STAT_ACQUISITION_START_TRIGGER_BIT] = acquisition_start_trigger;
        nxt_prdata[STAT_POSTTRIGGER_START_TRIGGER_BIT] = posttrigger_start_trigger;
      end
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ------------------------------------------------------------
  // digital line registers
  // ------------------------------------------------------------
  // reset clears every direction bit, so no line drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dio_dir_ff <= DIO_RESET;
      dio_out_ff <= DIO_RESET;
    end else if (wr_en) begin
      if (paddr == ADDR_DIO_DIR) begin
        dio_dir_ff <= pwdata[DIO_LINES-1:0];
      end
      if (paddr == ADDR_DIO_OUT) begin
        dio_out_ff <= pwdata[DIO_LINES-1:0];
      end
    end
  end

  // one enable bit per line, each set alone
  assign gp_digital_lines_oe = dio_dir_ff;
  assign gp_digital_lines_out = dio_out_ff;

  // direction taps read the pins and never touch the line registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_zero_up_down_ff <= 1'b0;
      counter_one_up_down_ff <= 1'b0;
    end else begin
      counter_zero_up_down_ff <= gp_digital_lines_in[DIO_UPDOWN_CTR0];
      counter_one_up_down_ff <= gp_digital_lines_in[DIO_UPDOWN_CTR1];
    end
  end

  assign counter_zero_up_down = counter_zero_up_down_ff;
  assign counter_one_up_down = counter_one_up_down_ff;

  // ------------------------------------------------------------
  // pin enables, control and select registers
  // ------------------------------------------------------------
  // selects reset to the internal source so nothing follows a floating pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfi_oe_ff <= PFI_OE_RESET;
      ctrl_ff <= CTRL_RESET;
      sel_ff <= {NUM_SIG{SEL_INTERNAL}};
    end else if (wr_en) begin
      if (paddr == ADDR_PFI_OE) begin
        pfi_oe_ff <= pwdata[PFI_PINS-1:0];
      end
      if (paddr == ADDR_CTRL) begin
        ctrl_ff <= pwdata[CTRL_W-1:0];
      end
      if (paddr == ADDR_SEL_LO) begin
        sel_ff[SEL_W*SEL_PER_WORD-1:0] <= pwdata;
      end
      if (paddr == ADDR_SEL_HI) begin
        sel_ff[SEL_W*NUM_SIG-1:SEL_W*SEL_PER_WORD] <= pwdata[SEL_W*(NUM_SIG-SEL_PER_WORD)-1:0];
      end
    end
  end

  // the strobe level is a register bit, so only a write can move it
  assign software_strobe_n = ctrl_ff[CTRL_STROBE_N_BIT];

  // ------------------------------------------------------------
  // timebase divider
  // ------------------------------------------------------------
  // one-cycle enable at the timebase rate; a free-running count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tb_cnt_ff == ($clog2(TB_DIV_CYCLES))'(TB_DIV_CYCLES - 1)) begin
      tb_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tb_cnt_ff <= tb_cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  assign timebase_tick = tick_ff;

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  // pin zero is withheld from the selectors while it feeds the analog trigger
  always_comb begin
    pfi_to_selectors = programmable_function_pin_in;
    if (ctrl_ff[CTRL_ANALOG_TRIG_BIT]) begin
      pfi_to_selectors[0] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_trigger_in_ff <= 1'b0;
    end else begin
      analog_trigger_in_ff <= ctrl_ff[CTRL_ANALOG_TRIG_BIT] & programmable_function_pin_in[0];
    end
  end

  assign analog_trigger_in = analog_trigger_in_ff;

  // the conversion strobe's internal source is the sample interval count
  assign internal_src = {internal_timing_src, sample_interval_terminal_count};

  // each selector sees all pins; shared pins are just fan-out
  genvar s;
  generate
    for (s = 0; s < TIMING_SIGNALS; s++) begin : g_sel
      timing_source_select #(
        .PINS(PFI_PINS)
      ) u_sel (
        .pclk(pclk),
        .presetn(presetn),
        .sel(sel_ff[SEL_W*s +: SEL_W]),
        .pin_in(pfi_to_selectors),
        .internal_src(internal_src[s]),
        .counter_zero_output(counter_zero_output),
        .routed_ff(routed[s])
      );
    end
  endgenerate

  assign routed_timing = routed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routed_prev_ff <= '0;
    end else begin
      routed_prev_ff <= routed;
    end
  end

  assign routed_rise = routed & ~routed_prev_ff;

  // ------------------------------------------------------------
  // acquisition sequence
  // ------------------------------------------------------------
  // mode is sampled at the start trigger; a done pulse ends any sequence
  always_comb begin
    nxt_acq_state = acq_state_ff;
    unique case (acq_state_ff)
      ACQ_IDLE: begin
        if (routed_rise[SIG_ACQ_TRIG]) begin
          nxt_acq_state = ctrl_ff[CTRL_PRETRIG_BIT] ? ACQ_PRETRIG : ACQ_POSTONLY;
        end
      end
      ACQ_POSTONLY: begin
        if (acquisition_done) begin
          nxt_acq_state = ACQ_IDLE;
        end
      end
      ACQ_PRETRIG: begin
        if (acquisition_done) begin
          nxt_acq_state = ACQ_IDLE;
        end else if (routed_rise[SIG_POST_TRIG]) begin
          nxt_acq_state = ACQ_POSTTRIG;
        end
      end
      ACQ_POSTTRIG: begin
        if (acquisition_done) begin
          nxt_acq_state = ACQ_IDLE;
        end
      end
      default: nxt_acq_state = ACQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_state_ff <= ACQ_IDLE;
    end else begin
      acq_state_ff <= nxt_acq_state;
    end
  end

  // first trigger high for the whole sequence, second after post start in pretrigger mode only
  assign acquisition_start_trigger = (acq_state_ff != ACQ_IDLE);
  assign posttrigger_start_trigger = (acq_state_ff == ACQ_POSTTRIG);

  // ------------------------------------------------------------
  // strobe pulse generators
  // ------------------------------------------------------------
  // 0: conversion, 1: update, 2: scan start, 3: per conversion scan pulse
  assign evt[0] = routed_rise[SIG_CONVERT];
  assign evt[1] = routed_rise[SIG_UPDATE];
  assign evt[2] = routed_rise[SIG_SCAN_START];
  assign evt[3] = routed_rise[SIG_CONVERT] & ctrl_ff[CTRL_SCAN_PULSE_EN_BIT];

  // each pulse lasts one timebase period; a new event restarts it
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_pulse
      logic [$clog2(TB_DIV_CYCLES+1)-1:0] left_ff;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          left_ff <= '0;
          pulse_ff[p] <= 1'b0;
        end else if (evt[p]) begin
          left_ff <= ($clog2(TB_DIV_CYCLES+1))'(TB_DIV_CYCLES - 1);
          pulse_ff[p] <= 1'b1;
        end else if (left_ff != '0) begin
          left_ff <= left_ff - 1'b1;
        end else begin
          pulse_ff[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // rising edge comes after the conversion event, when the sample is held
  assign per_conversion_scan_pulse = pulse_ff[3];

  // ------------------------------------------------------------
  // function pin drivers
  // ------------------------------------------------------------
  // conversion and update strobes are active low, so the pulse falls
  always_comb begin
    nxt_pfi_out = '0;
    nxt_pfi_out[0] = acquisition_start_trigger;
    nxt_pfi_out[1] = posttrigger_start_trigger;
    nxt_pfi_out[2] = ~pulse_ff[0];
    nxt_pfi_out[3] = routed[SIG_CTR1_SRC];
    nxt_pfi_out[4] = routed[SIG_CTR1_GATE];
    nxt_pfi_out[5] = ~pulse_ff[1];
    nxt_pfi_out[6] = routed[SIG_WAVE_TRIG];
    nxt_pfi_out[7] = pulse_ff[2];
    nxt_pfi_out[8] = routed[SIG_CTR0_SRC];
    nxt_pfi_out[9] = routed[SIG_CTR0_GATE];
  end

  // one cycle later than the strobes; keeps pin data on flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfi_out_ff <= '0;
    end else begin
      pfi_out_ff <= nxt_pfi_out;
    end
  end

  // a clear enable leaves the pin undriven while selectors still read it
  assign programmable_function_pin_out = pfi_out_ff;
  assign programmable_function_pin_oe = pfi_oe_ff;

endmodule : timing_signal_router_dio

// ===== dv/timing_router_chk.sv
// assertions on the timing signal router's ports
module timing_router_chk
  import timing_router_pkg::*;
#(
  parameter int DIO_LINES = NUM_DIO,
  parameter int PFI_PINS = NUM_PFI,
  parameter int TIMING_SIGNALS = NUM_SIG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [DIO_LINES-1:0] gp_digital_lines_in,
  input wire logic [DIO_LINES-1:0] gp_digital_lines_oe,
  input wire logic [PFI_PINS-1:0] programmable_function_pin_out,
  input wire logic [PFI_PINS-1:0] programmable_function_pin_oe,
  input wire logic acquisition_done,
  input wire logic [TIMING_SIGNALS-1:0] routed_timing,
  input wire logic counter_zero_up_down,
  input wire logic per_conversion_scan_pulse,
  input wire logic software_strobe_n,
  input wire logic acquisition_start_trigger,
  input wire logic posttrigger_start_trigger
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // access-phase write
  logic wr;
  assign wr = psel && penable && pwrite;

  a_reset_pins_off: assert property (@(posedge pclk)
    !presetn |-> gp_digital_lines_oe == 8'h00 && programmable_function_pin_oe == 10'h000)
    else $error("drivers on during reset");
  a_updown_tap: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> counter_zero_up_down == $past(gp_digital_lines_in[DIO_UPDOWN_CTR0]))
    else $error("wrong counter 0 direction");
  a_dir_only_sw: assert property (@(posedge pclk) disable iff (!presetn)
    !wr && !$past(wr) && $past(presetn) |-> $stable(gp_digital_lines_oe))
    else $error("direction moved unwritten");
  a_pin_oe_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == ADDR_PFI_OE |=> programmable_function_pin_oe == $past(pwdata[PFI_PINS-1:0]))
    else $error("pin enables not written");
  a_convert_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(routed_timing[SIG_CONVERT]) |-> ##2 !programmable_function_pin_out[2] [*2])
    else $error("conversion strobe did not fall");
  a_update_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(routed_timing[SIG_UPDATE]) |-> ##2 !programmable_function_pin_out[5] [*2])
    else $error("update strobe did not fall");
  a_scan_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(routed_timing[SIG_SCAN_START]) |-> ##2 programmable_function_pin_out[7] [*2])
    else $error("scan start did not pulse");
  a_scan_per_conv: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(per_conversion_scan_pulse) |-> $past(routed_timing[SIG_CONVERT]) && !$past(routed_timing[SIG_CONVERT], 2))
    else $error("scan pulse without a conversion");
  a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(routed_timing[SIG_ACQ_TRIG]) && !acquisition_start_trigger && !acquisition_done
    |-> ##[1:2] acquisition_start_trigger)
    else $error("first trigger did not rise");
  a_posttrigger_start_trigger_inside: assert property (@(posedge pclk) disable iff (!presetn)
    posttrigger_start_trigger |-> acquisition_start_trigger)
    else $error("second trigger outside a sequence");
  a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
    acquisition_done |=> !acquisition_start_trigger && !posttrigger_start_trigger)
    else $error("triggers still high after done");
  a_strobe_sw: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == ADDR_CTRL) |=> $stable(software_strobe_n))
    else $error("strobe moved without a write");
endmodule : timing_router_chk

bind timing_signal_router_dio timing_router_chk #(.DIO_LINES(DIO_LINES), .PFI_PINS(PFI_PINS),
  .TIMING_SIGNALS(TIMING_SIGNALS)) timing_router_chk_i (.*);

// ===== dv/ext_board.sv
// far-side board model: drives connector pins and follows the scan pulse
module ext_board #(
  parameter int DIO_LINES = 8,
  parameter int PFI_PINS = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIO_LINES-1:0] dio_drv,
  input wire logic [DIO_LINES-1:0] dio_en,
  input wire logic [PFI_PINS-1:0] pfi_drv,
  input wire logic [PFI_PINS-1:0] pfi_en,
  input wire logic [DIO_LINES-1:0] dio_out,
  input wire logic [DIO_LINES-1:0] dio_oe,
  input wire logic [PFI_PINS-1:0] pfi_out,
  input wire logic [PFI_PINS-1:0] pfi_oe,
  input wire logic scan_pulse,
  output logic [DIO_LINES-1:0] dio_lvl,
  output logic [PFI_PINS-1:0] pfi_lvl,
  output logic [7:0] switch_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // device driver wins; a line nobody drives floats to its pull-up
  assign dio_lvl = (dio_oe & dio_out) | (~dio_oe & ((dio_en & dio_drv) | ~dio_en));
  assign pfi_lvl = (pfi_oe & pfi_out) | (~pfi_oe & ((pfi_en & pfi_drv) | ~pfi_en));
  // the analog source only moves on once the scan pulse rises
  logic scan_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_q <= 1'b0;
      switch_cnt <= 8'h00;
    end else begin
      scan_q <= scan_pulse;
      if (scan_pulse && !scan_q) switch_cnt <= switch_cnt + 8'h01;
    end
  end
endmodule : ext_board

// ===== dv/tb.sv
// self-checking bench: apb register tasks and pin-level scenarios
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timing_router_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] gp_digital_lines_in, gp_digital_lines_out, gp_digital_lines_oe, sw_cnt;
  logic [9:0] programmable_function_pin_in, programmable_function_pin_out, programmable_function_pin_oe;
  logic sample_interval_terminal_count = 1'b0, counter_zero_output = 1'b0, acquisition_done = 1'b0;
  logic [12:1] internal_timing_src = 12'h000;
  logic [12:0] routed_timing;
  logic counter_zero_up_down, counter_one_up_down, analog_trigger_in, timebase_tick;
  logic per_conversion_scan_pulse, software_strobe_n, acquisition_start_trigger, posttrigger_start_trigger;
  logic [7:0] dio_drv = 8'h00, dio_en = 8'h00;
  logic [9:0] pfi_drv = 10'h000, pfi_en = 10'h000;
  int n_mismatch = 0, checks = 0, cycles = 0;

  timing_signal_router_dio timing_signal_router_dio_i (.*);
  ext_board ext_board_i (.*, .dio_out(gp_digital_lines_out),
    .dio_oe(gp_digital_lines_oe), .pfi_out(programmable_function_pin_out), .pfi_oe(programmable_function_pin_oe),
    .scan_pulse(per_conversion_scan_pulse), .dio_lvl(gp_digital_lines_in),
    .pfi_lvl(programmable_function_pin_in), .switch_cnt(sw_cnt));

  // ----------------------------------------
  // clock, timeout and tasks
  // ----------------------------------------
  always #12.5 pclk = ~pclk;
  // run needs under a thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic go(input int n);
    repeat (n) @(posedge pclk);
  endtask : go

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    go(6);
    presetn <= 1'b1;
    #1;
    chk("dio oe", 32'(gp_digital_lines_oe), 32'h0);
    chk("pin oe", 32'(programmable_function_pin_oe), 32'h0);
    apb(ADDR_SEL_LO, 1'b0, 32'h0);
    chk("sel lo", rd, {8{SEL_INTERNAL}});
    apb(ADDR_SEL_HI, 1'b0, 32'h0);
    chk("sel hi", rd, 32'({5{SEL_INTERNAL}}));
    apb(ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl", rd, 32'(CTRL_RESET));
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    // lines 1,3,4 driven by the device, the rest by the far board
    dio_en <= 8'he5;
    dio_drv <= 8'h81;
    apb(ADDR_DIO_DIR, 1'b1, 32'h1a);
    apb(ADDR_DIO_OUT, 1'b1, 32'h3c);
    go(4);
    apb(ADDR_DIO_IN, 1'b0, 32'h0);
    chk("dio in", rd, 32'h99);
    chk("up down", 32'({counter_zero_up_down, counter_one_up_down}), 32'h1);
    dio_drv <= 8'h40;
    go(4);
    #1;
    chk("up down", 32'({counter_zero_up_down, counter_one_up_down}), 32'h2);
    chk("dio drive", 32'({gp_digital_lines_oe, gp_digital_lines_out}), 32'h1a3c);
    // codes 0 to 11 for all signals at once: pins, internal, counter 0
    pfi_en <= 10'h3ff;
    for (int k = 0; k < 12; k++) begin
      apb(ADDR_SEL_LO, 1'b1, {8{4'(k)}});
      apb(ADDR_SEL_HI, 1'b1, 32'({5{4'(k)}}));
      pfi_drv <= (k < 10) ? 10'(1 << k) : 10'h000;
      sample_interval_terminal_count <= (k == 10);
      internal_timing_src <= (k == 10) ? 12'hfff : 12'h000;
      counter_zero_output <= (k == 11);
      go(3);
      #1;
      chk("routed", 32'(routed_timing), 32'h1fff);
      go(1);
      pfi_drv <= 10'h000;
      sample_interval_terminal_count <= 1'b0;
      internal_timing_src <= 12'h000;
      counter_zero_output <= 1'b0;
      go(3);
      #1;
      chk("routed", 32'(routed_timing), 32'h0);
    end
    apb(ADDR_SEL_LO, 1'b1, 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h9);
    pfi_drv <= 10'h001;
    go(3);
    #1;
    chk("pin zero", 32'({analog_trigger_in, routed_timing[7:0]}), 32'h100);
    go(1);
    pfi_drv <= 10'h000;
    apb(ADDR_SEL_LO, 1'b1, {8{SEL_INTERNAL}});
    apb(ADDR_SEL_HI, 1'b1, 32'({5{SEL_INTERNAL}}));
    apb(ADDR_CTRL, 1'b1, 32'hc);
    apb(ADDR_PFI_OE, 1'b1, 32'h3ff);
    sample_interval_terminal_count <= 1'b1;
    internal_timing_src[2:1] <= 2'h3;
    go(1);
    sample_interval_terminal_count <= 1'b0;
    internal_timing_src[2:1] <= 2'h0;
    go(2);
    #1;
    chk("strobes", 32'(programmable_function_pin_out & 10'h0a4), 32'h080);
    chk("pin level", 32'(programmable_function_pin_in), 32'(programmable_function_pin_out));
    chk("scan pulse", 32'({per_conversion_scan_pulse, software_strobe_n}), 32'h3);
    go(4);
    chk("switches", 32'(sw_cnt), 32'h1);
    apb(ADDR_CTRL, 1'b1, 32'h4);
    go(2);
    #1;
    chk("strobe n", 32'(software_strobe_n), 32'h0);
    rd[0] = timebase_tick;
    go(1);
    #1;
    chk("tick", 32'(rd[0] ^ timebase_tick), 32'h1);
    // posttrigger-only run, then a pretrigger run
    for (int m = 0; m < 2; m++) begin
      go(1);
      acquisition_done <= 1'b1;
      go(1);
      acquisition_done <= 1'b0;
      apb(ADDR_CTRL, 1'b1, 32'(m * 2 + 8));
      internal_timing_src[3] <= 1'b1;
      go(4);
      #1;
      chk("acquisition_start_trigger", 32'({posttrigger_start_trigger, acquisition_start_trigger, programmable_function_pin_out[0]}),
        32'h3);
      go(1);
      internal_timing_src[4] <= 1'b1;
      go(4);
      #1;
      chk("posttrigger_start_trigger", 32'({posttrigger_start_trigger, programmable_function_pin_out[1]}), (m == 1) ? 32'h3 : 32'h0);
      go(1);
      internal_timing_src[4:3] <= 2'h0;
      acquisition_done <= 1'b1;
      go(1);
      acquisition_done <= 1'b0;
      go(1);
      #1;
      chk("idle", 32'({acquisition_start_trigger, posttrigger_start_trigger}), 32'h0);
    end
    go(2);
    end_of_test();
  end
endmodule : tb
